// ### core/isp_prioritizer.v
// Interrupt source prioritizer: NMI edge, encoded level pins, peripheral levels, APB registers
// Functional notes
// R01: Levels 0..16, highest wins, zero masked
// R02: NMI level 16, edge, blocked by block bit
// R03: Sleep or standby accepts NMI despite block
// R04: NMI edge chosen by edge-select bit
// R05: Ignore NMI 20 cycles after edge change
// R06: Never write CPU mask level
// R07: Active-low pins, level is 15 minus value
// R08: Pin level needs two agreeing samples
// R09: Standby filtering uses timekeeping clock enable
// R10: Requester holds level until accepted
// R11: Five peripheral modules feed requests
// R12: Per-module level 0..15 in two registers
// R13: Distinct event code per source
// R14: Reset clears all module levels
// R15: Equal levels resolved by fixed ranking
// R16: Software updates flags only while blocked
// R17: Software rewrites priorities only while blocked
// R18: Racing flag update may give code 0
// R19: NMI 1C0, pins 200 step 20
// R20: Timer codes 400..460, underflow beats capture
// R21: Edge bit 0 falling, 1 rising, reset 0
// R22: Field value maps directly to level
// R23: Forward only above CPU mask level
// R24: Accept drives notify output low; code drives it low while a request is forwarded
// R25: Levels held, arbitration every cycle
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "isp_consts.vh"

module isp_prioritizer (
  // Clock and reset
  input  wire        I_CLOCK,
  input  wire        I_SRST,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [11:0] I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output wire        O_PREADY,
  output wire        O_PSLVERR,
  // External pins
  input  wire        I_NONMASKABLE_PIN,
  input  wire [3:0]  I_ENCODED_LEVEL_PINS_N,
  output reg         O_REQUEST_NOTIFY_OUT_N,
  // Clock enables and power state
  input  wire        I_PERIPH_CLK_EN,
  input  wire        I_RTC_CLK_EN,
  input  wire        I_STANDBY,
  input  wire        I_SLEEP,
  // Peripheral requests
  input  wire [2:0]  I_TIMER_UNDERFLOW,
  input  wire        I_TIMER2_CAPTURE,
  input  wire [2:0]  I_RTC_REQ,
  input  wire [3:0]  I_SERIAL_REQ,
  input  wire        I_WATCHDOG_REQ,
  input  wire [1:0]  I_REFRESH_REQ,
  // CPU side
  input  wire        I_CPU_BLOCK_BIT,
  input  wire [3:0]  I_CPU_MASK_LEVEL,
  input  wire        I_CPU_ACCEPT,
  output reg         O_CPU_IRQ,
  output reg  [4:0]  O_CPU_IRQ_LEVEL,
  output reg  [11:0] O_EVENT_CODE
);

  reg  [15:0] prio_a_q;
  reg  [15:0] prio_b_q;
  reg         edge_sel_q;
  reg  [4:0]  blank_q;
  reg  [2:0]  nmi_sync_q;
  reg         nmi_level_q;
  reg         nmi_pend_q;
  reg  [3:0]  pin_s1_q;
  reg  [3:0]  pin_s2_q;
  reg  [3:0]  pin_s3_q;
  reg  [3:0]  pin_filt_q;
  reg  [3:0]  pin_prev_q;
  reg  [11:0] event_q;

  wire        wr_en;
  wire        rd_en;
  wire        sample_en;
  wire        nmi_edge;
  wire        nmi_ok;
  wire [4:0]  pin_level;
  wire        accept_hit;
  wire        edge_change;
  wire        blank_on;
  wire        low_power;
  wire [12:0] unit_tmr2;
  wire [12:0] unit_rtc;
  wire [12:0] unit_ser;
  wire [12:0] unit_ref;

  reg         sel_ctrl;
  reg         sel_prio_a;
  reg         sel_prio_b;
  reg         sel_event;

  reg  [4:0]  win_level;
  reg  [11:0] win_code;

  // Keep the stronger candidate; strict compare keeps the earlier (higher ranked) one
  function [16:0] isp_pick;
    input [16:0] cur;
    input        req;
    input [3:0]  lvl;
    input [11:0] code;
    begin
      if (req && ({1'b0, lvl} > cur[16:12])) begin
        isp_pick = {1'b0, lvl, code};
      end else begin
        isp_pick = cur;
      end
    end
  endfunction

  // Rank inside one priority unit: lowest request index wins, codes step by 20h
  function [12:0] isp_unit;
    input [3:0]  req;
    input [11:0] base;
    begin
      if (req[0]) begin
        isp_unit = {1'b1, base};
      end else if (req[1]) begin
        isp_unit = {1'b1, base + 12'h020};
      end else if (req[2]) begin
        isp_unit = {1'b1, base + 12'h040};
      end else if (req[3]) begin
        isp_unit = {1'b1, base + 12'h060};
      end else begin
        isp_unit = {1'b0, base};
      end
    end
  endfunction

  // Active-low pin pattern to level: all ones means no request
  function [4:0] isp_pin_level;
    input [3:0] pins_n;
    begin
      isp_pin_level = {1'b0, 4'hF - pins_n};
    end
  endfunction

  // Pin event code rises one step per pattern above the base
  function [11:0] isp_pin_code;
    input [3:0] pins_n;
    begin
      isp_pin_code = `ISP_CODE_PIN_BASE + {3'h0, pins_n, 5'h00};
    end
  endfunction

  // Register select, one word at a time
  always @* begin
    sel_ctrl   = 1'b0;
    sel_prio_a = 1'b0;
    sel_prio_b = 1'b0;
    sel_event  = 1'b0;
    if (I_PADDR == `ISP_OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (I_PADDR == `ISP_OFF_PRIO_A) begin
      sel_prio_a = 1'b1;
    end else if (I_PADDR == `ISP_OFF_PRIO_B) begin
      sel_prio_b = 1'b1;
    end else if (I_PADDR == `ISP_OFF_EVENT) begin
      sel_event = 1'b1;
    end
  end

  // Accept only counts when the CPU was really shown a request
  assign accept_hit  = I_CPU_ACCEPT & O_CPU_IRQ;
  assign edge_change = (I_PWDATA[`ISP_CTRL_EDGE_SEL] != edge_sel_q);
  assign blank_on    = (blank_q != 5'h00);
  assign low_power   = I_SLEEP | I_STANDBY;

  // Units sharing one priority field
  assign unit_tmr2 = isp_unit({2'b00, I_TIMER2_CAPTURE, I_TIMER_UNDERFLOW[2]}, `ISP_CODE_TMR2); // R20
  assign unit_rtc  = isp_unit({1'b0, I_RTC_REQ}, `ISP_CODE_RTC_ALARM);
  assign unit_ser  = isp_unit(I_SERIAL_REQ, `ISP_CODE_SER_ERR);
  assign unit_ref  = isp_unit({2'b00, I_REFRESH_REQ}, `ISP_CODE_REF_MATCH);

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_en = I_PSEL & ~I_PENABLE & ~I_PWRITE;

  // Register writes
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      prio_a_q   <= `ISP_PRIO_RESET; // R14
      prio_b_q   <= `ISP_PRIO_RESET; // R14
      edge_sel_q <= `ISP_EDGE_RESET; // R21
      blank_q    <= 5'h00;
    end else begin
      if (blank_on) begin
        blank_q <= blank_q - 5'h01;
      end
      if (wr_en) begin
        if (sel_ctrl) begin
          edge_sel_q <= I_PWDATA[`ISP_CTRL_EDGE_SEL];
          if (edge_change) begin
            blank_q <= `ISP_EDGE_BLANK_CYC; // R05
          end
        end else if (sel_prio_a) begin
          prio_a_q <= I_PWDATA[15:0]; // R12
        end else if (sel_prio_b) begin
          prio_b_q <= {I_PWDATA[15:4], 4'h0}; // R12
        end
      end
    end
  end

  // Read data, registered in the setup cycle so it stands in the access phase
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_PRDATA <= 32'h00000000;
    end else if (rd_en) begin
      if (sel_ctrl) begin
        O_PRDATA <= {16'h0000, nmi_level_q, 6'h00, edge_sel_q, 8'h00};
      end else if (sel_prio_a) begin
        O_PRDATA <= {16'h0000, prio_a_q};
      end else if (sel_prio_b) begin
        O_PRDATA <= {16'h0000, prio_b_q};
      end else if (sel_event) begin
        O_PRDATA <= {20'h00000, event_q};
      end else begin
        O_PRDATA <= 32'h00000000;
      end
    end
  end

  // NMI pin: three flops, change counts when second and third agree
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      nmi_sync_q  <= 3'h0;
      nmi_level_q <= 1'b0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], I_NONMASKABLE_PIN};
      if (nmi_sync_q[1] == nmi_sync_q[2]) begin
        nmi_level_q <= nmi_sync_q[2];
      end
    end
  end

  // Edge of the filtered level, chosen by edge select
  assign nmi_edge = (nmi_sync_q[1] == nmi_sync_q[2]) && (nmi_sync_q[2] != nmi_level_q) &&
                    (nmi_sync_q[2] == edge_sel_q); // R04 R21

  // Cleared only when the CPU takes the NMI it was shown, else a fresh NMI could be lost
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge && !blank_on) begin
      nmi_pend_q <= 1'b1; // R02 R05
    end else if (accept_hit && (O_EVENT_CODE == `ISP_CODE_NMI)) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // Blocked NMI stays pending until block bit clears, except in low power
  assign nmi_ok = nmi_pend_q && (!I_CPU_BLOCK_BIT || low_power); // R02 R03

  // Encoded pins: peripheral clock enable, or timekeeping enable in standby
  assign sample_en = I_STANDBY ? I_RTC_CLK_EN : I_PERIPH_CLK_EN; // R09

  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      pin_s1_q   <= 4'hF;
      pin_s2_q   <= 4'hF;
      pin_s3_q   <= 4'hF;
      pin_prev_q <= 4'hF;
      pin_filt_q <= 4'hF;
    end else begin
      pin_s1_q <= I_ENCODED_LEVEL_PINS_N;
      pin_s2_q <= pin_s1_q;
      if (sample_en) begin
        pin_s3_q   <= pin_s2_q;
        pin_prev_q <= pin_s3_q;
        if (pin_s3_q == pin_prev_q) begin
          pin_filt_q <= pin_s3_q; // R08
        end
      end
    end
  end

  assign pin_level = isp_pin_level(pin_filt_q); // R07

  // Arbitration, re-run every cycle over held levels
  always @* begin : arb
    reg [16:0] c;
    c = {`ISP_LEVEL_NONE, 12'h000}; // R01
    c = isp_pick(c, I_TIMER_UNDERFLOW[0], prio_a_q[15:12], `ISP_CODE_TMR0); // R11 R22
    c = isp_pick(c, I_TIMER_UNDERFLOW[1], prio_a_q[11:8], `ISP_CODE_TMR1);
    c = isp_pick(c, unit_tmr2[12], prio_a_q[7:4], unit_tmr2[11:0]); // R20
    c = isp_pick(c, unit_rtc[12], prio_a_q[3:0], unit_rtc[11:0]);
    c = isp_pick(c, unit_ser[12], prio_b_q[7:4], unit_ser[11:0]);
    c = isp_pick(c, I_WATCHDOG_REQ, prio_b_q[15:12], `ISP_CODE_WDOG);
    c = isp_pick(c, unit_ref[12], prio_b_q[11:8], unit_ref[11:0]); // R25
    // Pins go after modules; a tie goes to the pins since they rank higher
    if ((pin_level != `ISP_LEVEL_NONE) && (pin_level >= c[16:12])) begin
      c = {pin_level, isp_pin_code(pin_filt_q)}; // R15 R19
    end
    if (nmi_ok) begin
      c = {`ISP_LEVEL_NMI, `ISP_CODE_NMI}; // R02 R15 R19
    end
    win_level = c[16:12];
    win_code  = c[11:0]; // R13
  end

  // Outputs to CPU; mask level is only read, never driven
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_CPU_IRQ              <= 1'b0;
      O_CPU_IRQ_LEVEL        <= 5'h00;
      O_EVENT_CODE           <= 12'h000;
      O_REQUEST_NOTIFY_OUT_N <= 1'b1;
      event_q                <= 12'h000;
    end else begin
      O_CPU_IRQ              <= (win_level > {1'b0, I_CPU_MASK_LEVEL}); // R23 R06
      O_CPU_IRQ_LEVEL        <= win_level;
      O_EVENT_CODE           <= win_code;
      O_REQUEST_NOTIFY_OUT_N <= ~(win_level > {1'b0, I_CPU_MASK_LEVEL}); // R24
      if (I_CPU_ACCEPT) begin
        // Code may read 0 if the request vanished under a racing flag update
        event_q <= O_CPU_IRQ ? O_EVENT_CODE : 12'h000; // R18
      end
    end
  end

endmodule
`default_nettype wire

// ### pkg/isp_consts.vh
// Register offsets, field positions, reset values and timing counts of the interrupt prioritizer
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH

// APB byte offsets (printed offsets are multiples of two, so indexes times four)
`define ISP_IDX_CTRL          2'h0
`define ISP_IDX_PRIO_A        2'h1
`define ISP_IDX_PRIO_B        2'h2
`define ISP_IDX_EVENT         2'h3
`define ISP_OFF_CTRL          12'h000
`define ISP_OFF_PRIO_A        12'h004
`define ISP_OFF_PRIO_B        12'h008
`define ISP_OFF_EVENT         12'h00C

// Control register fields
`define ISP_CTRL_PIN_LEVEL    15
`define ISP_CTRL_EDGE_SEL     8

// Reset values
`define ISP_PRIO_RESET        16'h0000
`define ISP_EDGE_RESET        1'b0

// Levels
`define ISP_LEVEL_NMI         5'h10
`define ISP_LEVEL_NONE        5'h00

// Event codes
`define ISP_CODE_NMI          12'h1C0
`define ISP_CODE_PIN_BASE     12'h200
`define ISP_CODE_TMR0         12'h400
`define ISP_CODE_TMR1         12'h420
`define ISP_CODE_TMR2         12'h440
`define ISP_CODE_TMR2_CAP     12'h460
`define ISP_CODE_RTC_ALARM    12'h480
`define ISP_CODE_RTC_PERIOD   12'h4A0
`define ISP_CODE_RTC_CARRY    12'h4C0
`define ISP_CODE_SER_ERR      12'h4E0
`define ISP_CODE_SER_RX       12'h500
`define ISP_CODE_SER_TX       12'h520
`define ISP_CODE_SER_END      12'h540
`define ISP_CODE_WDOG         12'h560
`define ISP_CODE_REF_MATCH    12'h580
`define ISP_CODE_REF_OVF      12'h5A0

// Edge-select blanking after a control write that changes the edge-select bit, in cycles
`define ISP_EDGE_BLANK_CYC    5'h14

`endif

// ### sim/isp_prioritizer_asserts.sv
// Port checker for the interrupt prioritizer
`timescale 1ns/10ps
`default_nettype none
module isp_asserts (
  input wire logic        I_CLOCK,
  input wire logic        I_SRST,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [3:0]  I_ENCODED_LEVEL_PINS_N,
  input wire logic        I_SLEEP,
  input wire logic        I_STANDBY,
  input wire logic        I_CPU_BLOCK_BIT,
  input wire logic [3:0]  I_CPU_MASK_LEVEL,
  input wire logic        O_REQUEST_NOTIFY_OUT_N,
  input wire logic        O_CPU_IRQ,
  input wire logic [4:0]  O_CPU_IRQ_LEVEL,
  input wire logic [11:0] O_EVENT_CODE
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  wire nmi_fwd = O_CPU_IRQ && O_EVENT_CODE == 12'h1C0;
  wire pin_fwd = O_CPU_IRQ && O_EVENT_CODE >= 12'h200 && O_EVENT_CODE <= 12'h3C0;
  // Filtered pins must have held one value across two samples (sync, sample, compare, forward)
  sequence s_pins_held;
    $past(I_ENCODED_LEVEL_PINS_N, 5) == $past(I_ENCODED_LEVEL_PINS_N, 6);
  endsequence
  a_bus_answer: assert property (O_PREADY && !O_PSLVERR) else $error("bus answer not ready");
  a_notify_mirror: assert property (O_REQUEST_NOTIFY_OUT_N == !O_CPU_IRQ) else $error("notify wrong");
  a_above_mask: assert property (O_CPU_IRQ |-> O_CPU_IRQ_LEVEL > {1'b0, $past(I_CPU_MASK_LEVEL)})
    else $error("request not above mask");
  a_level_range: assert property (O_CPU_IRQ |-> O_CPU_IRQ_LEVEL inside {[5'h01:5'h10]})
    else $error("level out of range");
  a_nmi_level: assert property (nmi_fwd |-> O_CPU_IRQ_LEVEL == 5'h10) else $error("nmi level wrong");
  a_pin_code: assert property (pin_fwd |-> O_EVENT_CODE == 12'h200 + 12'h020 * (12'h00F - 12'(O_CPU_IRQ_LEVEL)))
    else $error("pin code wrong");
  a_pin_filter: assert property ($rose(pin_fwd) && !I_STANDBY |-> s_pins_held) else $error("pin glitch passed");
  a_nmi_block: assert property (nmi_fwd && !$past(I_SLEEP) && !$past(I_STANDBY) |-> !$past(I_CPU_BLOCK_BIT))
    else $error("nmi passed block");
endmodule
bind isp_prioritizer isp_asserts isp_asserts_i (.I_CLOCK, .I_SRST, .O_PREADY, .O_PSLVERR, .I_ENCODED_LEVEL_PINS_N,
  .I_SLEEP, .I_STANDBY, .I_CPU_BLOCK_BIT, .I_CPU_MASK_LEVEL, .O_REQUEST_NOTIFY_OUT_N, .O_CPU_IRQ,
  .O_CPU_IRQ_LEVEL, .O_EVENT_CODE);
`default_nettype wire

// ### sim/isp_cpu_model.sv
// Behavioural CPU core taking forwarded requests
`timescale 1ns/10ps
`default_nettype none
module isp_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_irq,
  input  wire logic       i_take,
  input  wire logic [3:0] i_dly,
  output var  logic       o_accept
);
  int cnt = 0;
  logic busy = 1'b0;
  initial o_accept = 1'b0;
  // Instruction break comes a variable time after the request; one accept per take
  always @(posedge i_clk) begin
    o_accept <= 1'b0;
    if (!i_take) begin
      busy <= 1'b0;
    end
    if (!(i_irq && i_take) || busy) begin
      cnt <= 0;
    end else if (cnt == int'(i_dly)) begin
      o_accept <= 1'b1;
      busy <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### sim/isp_prioritizer_bench.sv
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/10ps
`default_nettype none
module isp_prioritizer_bench;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, nmi = 1'b1;
  logic        blk = 1'b0, slp = 1'b0, take = 1'b0;
  logic        pclk_en = 1'b1, rtc_en = 1'b0, stby = 1'b0, rtc_run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, rd;
  logic [3:0]  pins = 4'hF, mask = 4'h0, dly = 4'h0;
  logic [13:0] mreq = 14'h0000;
  wire  [31:0] prdata;
  wire         pready, pslverr, notify_n, acc, irq;
  wire  [4:0]  lvl;
  wire  [11:0] code;
  int          n_fail = 0, total_checks = 0, cyc = 0, lv;
  isp_prioritizer isp_prioritizer_i (.I_CLOCK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_NONMASKABLE_PIN(nmi), .I_ENCODED_LEVEL_PINS_N(pins),
    .O_REQUEST_NOTIFY_OUT_N(notify_n), .I_PERIPH_CLK_EN(pclk_en), .I_RTC_CLK_EN(rtc_en), .I_STANDBY(stby),
    .I_SLEEP(slp), .I_TIMER_UNDERFLOW(mreq[2:0]), .I_TIMER2_CAPTURE(mreq[3]), .I_RTC_REQ(mreq[6:4]),
    .I_SERIAL_REQ(mreq[10:7]), .I_WATCHDOG_REQ(mreq[11]), .I_REFRESH_REQ(mreq[13:12]),
    .I_CPU_BLOCK_BIT(blk), .I_CPU_MASK_LEVEL(mask), .I_CPU_ACCEPT(acc), .O_CPU_IRQ(irq),
    .O_CPU_IRQ_LEVEL(lvl), .O_EVENT_CODE(code));
  isp_cpu_model isp_cpu_model_i (.i_clk(clk), .i_irq(irq), .i_take(take), .i_dly(dly), .o_accept(acc));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rtc_en <= rtc_run && (cyc % 4 == 0);
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wt(input logic v);
    do @(posedge clk); while (irq !== v);
  endtask
  task automatic quiet(input int n);
    int s;
    s = 0;
    repeat (n) begin
      @(posedge clk);
      s = s | int'(irq !== 1'b0);
    end
    chk("idle irq", s, 0);
  endtask
  task automatic out(input logic [11:0] c, input logic [4:0] l);
    chk("event code", code, c);
    chk("level", lvl, l);
    chk("notify", notify_n, 1'b0);
  endtask
  task automatic win(input logic [11:0] c);
    int n;
    n = 0;
    while (code !== c && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("winner", code, c);
  endtask
  // Field position of each module source inside its priority register
  function automatic int sh(input int i);
    if (i < 2) return 12 - 4 * i;
    if (i < 4 || (i > 6 && i < 11)) return 4;
    if (i == 11) return 12;
    return i > 11 ? 8 : 0;
  endfunction
  initial begin
    void'($urandom(5704));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h000, '0);
    chk("ctrl", rd, 32'h0000_8000);
    apb(1'b0, 12'h004, '0);
    chk("prio a", rd, '0);
    apb(1'b0, 12'h008, '0);
    chk("prio b", rd, '0);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, '0);
    chk("unmapped", rd, '0);
    $display("done reset");
    nmi <= 1'b0;
    wt(1'b1);
    out(12'h1C0, 5'h10);
    dly <= 4'($urandom_range(7));
    take <= 1'b1;
    wt(1'b0);
    take <= 1'b0;
    apb(1'b0, 12'h00C, '0);
    chk("event reg", rd, 32'h0000_01C0);
    apb(1'b1, 12'h000, 32'h0000_0100);
    nmi <= 1'b1;
    quiet(12);
    apb(1'b0, 12'h000, '0);
    chk("ctrl", rd, 32'h0000_8100);
    quiet(10);
    nmi <= 1'b0;
    quiet(10);
    blk <= 1'b1;
    nmi <= 1'b1;
    quiet(10);
    slp <= 1'b1;
    wt(1'b1);
    out(12'h1C0, 5'h10);
    take <= 1'b1;
    wt(1'b0);
    take <= 1'b0;
    slp <= 1'b0;
    blk <= 1'b0;
    $display("done nmi");
    for (int p = 0; p < 15; p++) begin
      pins <= 4'(p);
      wt(1'b1);
      out(12'h200 + 12'(p) * 12'h020, 5'(15 - p));
      take <= 1'b1;
      wait (acc === 1'b1);
      take <= 1'b0;
      pins <= 4'hF;
      wt(1'b0);
    end
    pins <= 4'h0;
    @(posedge clk);
    pins <= 4'hF;
    quiet(10);
    $display("done pins");
    stby <= 1'b1;
    pclk_en <= 1'b0;
    pins <= 4'h5;
    quiet(12);
    rtc_run <= 1'b1;
    wt(1'b1);
    out(12'h2A0, 5'h0A);
    pins <= 4'hF;
    wt(1'b0);
    rtc_run <= 1'b0;
    stby <= 1'b0;
    pclk_en <= 1'b1;
    $display("done standby");
    for (int k = 0; k < 14; k++) begin
      lv = $urandom_range(15, 1);
      blk <= 1'b1;
      apb(1'b1, k < 7 ? 12'h004 : 12'h008, 32'(lv) << sh(k));
      apb(1'b0, k < 7 ? 12'h004 : 12'h008, '0);
      chk("prio", rd, 32'(lv) << sh(k));
      blk <= 1'b0;
      mreq[k] <= 1'b1;
      wt(1'b1);
      out(12'h400 + 12'(k) * 12'h020, 5'(lv));
      mask <= 4'(lv);
      wt(1'b0);
      blk <= 1'b1;
      mreq <= '0;
      mask <= 4'h0;
    end
    apb(1'b1, 12'h004, 32'h0000_5050);
    apb(1'b1, 12'h008, 32'h0000_0500);
    pins <= 4'hA;
    mreq <= 14'h300D;
    win(12'h340);
    pins <= 4'hF;
    win(12'h400);
    mreq[0] <= 1'b0;
    win(12'h440);
    mreq[2] <= 1'b0;
    win(12'h460);
    mreq <= '0;
    $display("done modules");
    wrap_up();
  end
endmodule
`default_nettype wire
